//--- logic/cdc_pkg.sv
// constants and state type for the codec serial rate and control port block
package cdc_pkg;
  // synchronised pin vector positions
  localparam int PIN_MCLK   = 0;
  localparam int PIN_SCLK   = 1;
  localparam int PIN_CS     = 2;
  localparam int PIN_CONTROL_BIT_CLOCK   = 3;
  localparam int PIN_CONTROL_SERIAL_IN   = 4;
  localparam int PIN_ADV    = 5;
  localparam int PIN_DI1    = 6;
  localparam int PIN_LCL    = 7;
  localparam int PIN_RCL    = 8;
  localparam int PIN_ERR    = 9;   // two bits
  localparam int PIN_MODE   = 11;  // three bits
  localparam int PIN_RATE   = 14;  // three bits
  localparam int PIN_BPF    = 17;  // two bits
  localparam int PIN_SLAVE  = 19;
  localparam int PIN_MULT   = 20;
  localparam int NSYNC      = 21;

  localparam int CTRL_W     = 24;
  localparam int RATIO_W    = 12;
  localparam int MULT_SHIFT = 4;   // times sixteen
  localparam int DIV_W      = RATIO_W + MULT_SHIFT + 8;
  localparam int MASK_POS   = 0;   // interrupt mask bit in the control word
  localparam int STAT_W     = 8;

  localparam logic [2:0] MODE_THREE = 3'h3;
  localparam logic [2:0] MODE_FOUR  = 3'h4;
  localparam logic [2:0] MODE_FIVE  = 3'h5;
  localparam logic [1:0] ERR_RANGE  = 2'h3;
  localparam logic [3:0] BPF_LOG_MAX = 4'h8; // frame select 0..3 -> 256,128,64,32

  localparam logic [CTRL_W-1:0]  CTRL_RESET  = 24'h000000;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 12'h000;
  localparam logic [RATIO_W-1:0] RATIO_MAX   = 12'hFFF;
  // select and control clock sit at their idle high level after reset
  localparam logic [NSYNC-1:0]   SYNC_RESET  = 21'h00000C;

  typedef struct packed {
    logic [NSYNC-1:0]   s1;
    logic [NSYNC-1:0]   s2;
    logic [NSYNC-1:0]   s3;
    logic [RATIO_W-1:0] edgeCnt;
    logic [RATIO_W-1:0] ratio;
    logic [DIV_W-1:0]   rateKey;
    logic               boot;
    logic               calStart;
    logic [CTRL_W-1:0]  shiftIn;
    logic [CTRL_W-1:0]  latched;
    logic [CTRL_W-1:0]  ctrlWord;
    logic [STAT_W-1:0]  statusSh;
    logic               ctrlOut;
    logic               irqPend;
    logic               pushReq;
    logic               overflow;
    logic               modeErr;
  } cdc_state_t;
endpackage

//--- logic/cdc_serial_rate_control.sv
// serial rate measurement, control port, interrupt and control word fifo
// Summary of operation
// - slave modes: count master clocks per bit clock, derive sample rate from it
// - frame length is one of 256, 128, 64 or 32 bits
// - in serial mode three only, clock multiplier slave sub-mode uses sixteen times the master clock count
// - reset clears every control word bit to zero
// - any change of selected sample rate starts calibration by itself
// - mode four: last eight output bits before select rises carry status
// - a control port read clears the interrupt unless a new unmasked event lands in the same cycle
// - serial modes 3, 4, 5 only; modes 1 and 2 unsupported
// - select low shifts data in and status out; select high latches data
// - control input sampled on falling, output changed on rising bit clock
// - unmasked interrupt on flag change, clip rise, or leaving range error
module cdc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } cdc_fifo_state_t;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("cdc_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  cdc_fifo_state_t  q;
  cdc_fifo_state_t  d;
  logic             doPush;
  logic             doPop;

  always_comb begin
    d        = q;
    outValid = (q.wp != q.rp);
    inReady  = (q.wp[AW-1:0] != q.rp[AW-1:0]) || (q.wp[AW] == q.rp[AW]);
    doPush   = inValid && inReady;
    doPop    = outValid && outReady;
    outData  = mem[q.rp[AW-1:0]];
    if (doPush) begin
      d.wp = q.wp + 1'b1;
    end
    if (doPop) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      mem[q.wp[AW-1:0]] <= inData;
    end
  end
endmodule

module cdc_serial_rate_control
  import cdc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              masterClockIn,
  input  wire logic              serialBitClock,
  input  wire logic              controlChipSelect,
  input  wire logic              controlBitClock,
  input  wire logic              controlSerialIn,
  input  wire logic              adcValidFlag,
  input  wire logic              digitalInputOne,
  input  wire logic              leftClipFlag,
  input  wire logic              rightClipFlag,
  input  wire logic [1:0]        bitClockError,
  input  wire logic [2:0]        serialModeSel,
  input  wire logic [2:0]        rateSelect,
  input  wire logic [1:0]        frameLengthSel,
  input  wire logic              slaveMode,
  input  wire logic              multiplierMode,
  input  wire logic              wordAccept,
  output logic                   controlSerialOut,
  output logic                   irqPinOut,
  output logic                   irqPinOe,
  output logic      [CTRL_W-1:0] controlWord,
  output logic      [RATIO_W-1:0] bitClockRatio,
  output logic      [DIV_W-1:0]  sampleRateKey,
  output logic                   calStart,
  output logic                   modeUnsupported,
  output logic                   ctrlOverflow
);
  cdc_state_t        q;
  cdc_state_t        d;
  logic              fifoInReady;
  logic              fifoOutValid;
  logic [CTRL_W-1:0] fifoOutData;
  logic [NSYNC-1:0]  pins;
  logic              mRise;
  logic              sRise;
  logic              csRise;
  logic              csFall;
  logic              cclkRise;
  logic              cclkFall;
  logic              modeFour;
  logic [DIV_W-1:0]  effRatio;
  logic [DIV_W-1:0]  rateKey;
  logic [3:0]        bpfLog;
  logic [STAT_W-1:0] statusByte;
  logic              irqEvent;
  logic [2:0]        mode;

  assign pins = {multiplierMode, slaveMode, frameLengthSel, rateSelect, serialModeSel,
                 bitClockError, rightClipFlag, leftClipFlag, digitalInputOne,
                 adcValidFlag, controlSerialIn, controlBitClock, controlChipSelect,
                 serialBitClock, masterClockIn};

  cdc_fifo #(
    .WIDTH (CTRL_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .inValid  (q.pushReq),
    .inReady  (fifoInReady),
    .inData   (q.latched),
    .outValid (fifoOutValid),
    .outReady (wordAccept),
    .outData  (fifoOutData)
  );

  always_comb begin
    d        = q;
    d.s1     = pins;
    d.s2     = q.s1;
    d.s3     = q.s2;
    mRise    = q.s2[PIN_MCLK] && !q.s3[PIN_MCLK];
    sRise    = q.s2[PIN_SCLK] && !q.s3[PIN_SCLK];
    csRise   = q.s2[PIN_CS] && !q.s3[PIN_CS];
    csFall   = !q.s2[PIN_CS] && q.s3[PIN_CS];
    cclkRise = q.s2[PIN_CONTROL_BIT_CLOCK] && !q.s3[PIN_CONTROL_BIT_CLOCK];
    cclkFall = !q.s2[PIN_CONTROL_BIT_CLOCK] && q.s3[PIN_CONTROL_BIT_CLOCK];
    mode     = q.s2[PIN_MODE +: 3];
    modeFour = (mode == MODE_FOUR);
    d.modeErr = !(mode == MODE_THREE || modeFour || mode == MODE_FIVE);

    // master clock edges per bit clock period
    if (sRise) begin
      d.ratio   = q.edgeCnt + RATIO_W'(mRise);
      d.edgeCnt = RATIO_RESET;
    end else if (mRise && q.edgeCnt != RATIO_MAX) begin
      d.edgeCnt = q.edgeCnt + 1'b1;
    end
    effRatio = DIV_W'(q.ratio);
    if (q.s2[PIN_MULT] && mode == MODE_THREE) begin
      effRatio = effRatio << MULT_SHIFT;
    end
    bpfLog  = BPF_LOG_MAX - {2'h0, q.s2[PIN_BPF +: 2]};
    rateKey = q.s2[PIN_SLAVE] ? (effRatio << bpfLog) : DIV_W'(q.s2[PIN_RATE +: 3]);
    d.rateKey  = rateKey;
    d.calStart = q.boot || (rateKey != q.rateKey);
    d.boot     = 1'b0;

    // control port, mode four only
    statusByte = {q.s2[PIN_ADV], q.s2[PIN_DI1], q.s2[PIN_LCL], q.s2[PIN_RCL],
                  q.s2[PIN_ERR +: 2], q.irqPend, q.modeErr};
    d.pushReq  = 1'b0;
    if (modeFour) begin
      if (csFall) begin
        // pre-rotated so the last eight bits of a frame come out msb first
        d.statusSh = {statusByte[STAT_W-2:0], statusByte[STAT_W-1]};
      end else if (!q.s2[PIN_CS] && cclkRise) begin
        d.ctrlOut  = q.statusSh[STAT_W-1];
        d.statusSh = {q.statusSh[STAT_W-2:0], q.statusSh[STAT_W-1]};
      end
      if (!q.s2[PIN_CS] && cclkFall) begin
        d.shiftIn = {q.shiftIn[CTRL_W-2:0], q.s2[PIN_CONTROL_SERIAL_IN]};
      end
      if (csRise) begin
        d.latched = q.shiftIn;
        d.pushReq = 1'b1;
      end
    end
    d.overflow = q.pushReq && !fifoInReady;
    if (fifoOutValid && wordAccept) begin
      d.ctrlWord = fifoOutData;
    end

    // interrupt sources; a new event outranks the read clear
    irqEvent = (q.s2[PIN_ADV] != q.s3[PIN_ADV]) || (q.s2[PIN_DI1] != q.s3[PIN_DI1])
               || (q.s2[PIN_LCL] && !q.s3[PIN_LCL]) || (q.s2[PIN_RCL] && !q.s3[PIN_RCL])
               || (q.s3[PIN_ERR +: 2] == ERR_RANGE && q.s2[PIN_ERR +: 2] != ERR_RANGE);
    d.irqPend = (irqEvent && !q.ctrlWord[MASK_POS])
                || (q.irqPend && !(modeFour && csRise));
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q          <= '0;
      q.s1       <= SYNC_RESET;
      q.s2       <= SYNC_RESET;
      q.s3       <= SYNC_RESET;
      q.boot     <= 1'b1;
      q.ctrlWord <= CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // open drain: data stays low, only the enable pulls the line
  assign irqPinOut        = 1'b0;
  assign irqPinOe         = q.irqPend;
  assign controlSerialOut = q.ctrlOut;
  assign controlWord      = q.ctrlWord;
  assign bitClockRatio    = q.ratio;
  assign sampleRateKey    = q.rateKey;
  assign calStart         = q.calStart;
  assign modeUnsupported  = q.modeErr;
  assign ctrlOverflow     = q.overflow;
endmodule

//--- testbench/cdc_far_model.sv
// clock sources of the audio serial port host
module cdc_far_model (
  output logic masterClockIn,
  output logic serialBitClock
);
  timeunit 1ns;
  timeprecision 1ns;
  // 200 ns master against 400 ns bit clock: two master periods per bit
  initial begin
    {masterClockIn, serialBitClock} = 2'h0;
    #13;
    fork
      forever #100 masterClockIn = ~masterClockIn;
      forever #200 serialBitClock = ~serialBitClock;
    join
  end
endmodule

//--- testbench/cdc_checker.sv
// assertions on the codec serial rate and control port block
module cdc_checker
  import cdc_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire logic [2:0]         serialModeSel,
  input wire logic [1:0]         frameLengthSel,
  input wire logic               slaveMode,
  input wire logic               multiplierMode,
  input wire logic               wordAccept,
  input wire logic               irqPinOe,
  input wire logic [CTRL_W-1:0]  controlWord,
  input wire logic [RATIO_W-1:0] bitClockRatio,
  input wire logic [DIV_W-1:0]   sampleRateKey,
  input wire logic               calStart,
  input wire logic               modeUnsupported
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic modeOk = serialModeSel inside {MODE_THREE, MODE_FOUR, MODE_FIVE};
  wire logic slave3 = slaveMode && serialModeSel == MODE_THREE;
  wire logic [13:0] keyIn = {frameLengthSel, bitClockRatio};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  reset_zero_a: assert property ($rose(rstn) |-> controlWord == CTRL_RESET)
    else $error("control word not clear");
  word_accept_a: assert property (!$stable(controlWord) |-> $past(wordAccept))
    else $error("word applied without accept");
  cal_start_a: assert property (!$stable(sampleRateKey) |-> ##[0:1] calStart)
    else $error("no calibration on rate change");
  mode_bad_a: assert property ((!modeOk)[*6] |-> modeUnsupported)
    else $error("unsupported mode not flagged");
  mode_good_a: assert property (modeOk[*6] |-> !modeUnsupported)
    else $error("supported mode flagged");
  key_slave_a: assert property ((slave3 && !multiplierMode && $stable(keyIn))[*6]
    |-> sampleRateKey == DIV_W'(bitClockRatio) << (8 - frameLengthSel))
    else $error("slave rate key wrong");
  key_mult_a: assert property ((slave3 && multiplierMode && $stable(keyIn))[*6]
    |-> sampleRateKey == DIV_W'(bitClockRatio) << (12 - frameLengthSel))
    else $error("multiplier rate key wrong");
  irq_mask_a: assert property (controlWord[MASK_POS][*3] |-> !$rose(irqPinOe))
    else $error("masked interrupt raised");
  cover property (calStart);
  cover property ($rose(irqPinOe));
  cover property ($fell(irqPinOe));
endmodule
bind cdc_serial_rate_control cdc_checker u_chk (.*);

//--- testbench/tb_top.sv
// bench: control port frames, interrupts, fifo stall and rate key
module tb_top import cdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, masterClockIn, serialBitClock, controlChipSelect, controlBitClock;
  logic controlSerialIn, adcValidFlag, digitalInputOne, leftClipFlag, rightClipFlag;
  logic slaveMode, multiplierMode, wordAccept, controlSerialOut, irqPinOut, irqPinOe;
  logic calStart, modeUnsupported, ctrlOverflow;
  logic [1:0] bitClockError, frameLengthSel;
  logic [2:0] serialModeSel, rateSelect;
  logic [CTRL_W-1:0] controlWord;
  logic [RATIO_W-1:0] bitClockRatio;
  logic [DIV_W-1:0] sampleRateKey;
  logic [7:0] got;
  int mismatches, testsRun, calCnt, ovfCnt;
  cdc_serial_rate_control u_dut (.*);
  cdc_far_model u_far (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    calCnt += (calStart === 1'b1);
    ovfCnt += (ctrlOverflow === 1'b1);
  end
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #5;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // n bits of w msb first; data flips at each rise so only the fall may take it
  task automatic frame(input logic [31:0] w, input int n);
    controlChipSelect = 1'b0;
    step(4);
    for (int i = n - 1; i >= 0; i--) begin
      controlSerialIn = w[i];
      step(4);
      got = {got[6:0], controlSerialOut};
      controlBitClock = 1'b0;
      step(4);
      controlSerialIn = ~w[i];
      controlBitClock = 1'b1;
      step(4);
    end
    controlChipSelect = 1'b1;
    step(12);
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end
  initial begin
    rstn = 1'b0;
    {controlChipSelect, controlBitClock, wordAccept, controlSerialIn} = 4'hE;
    {adcValidFlag, digitalInputOne, leftClipFlag, rightClipFlag} = 4'h0;
    {slaveMode, multiplierMode, bitClockError, frameLengthSel} = 6'h00;
    serialModeSel = MODE_FOUR;
    rateSelect = 3'h0;
    got = 8'h00;
    step(5);
    rstn = 1'b1;
    step(2);
    chk(controlWord, 24'h000000);
    {adcValidFlag, leftClipFlag, rightClipFlag, bitClockError} = 5'h1E;
    step(8);
    chk(irqPinOe, 1'b1);
    chk(irqPinOut, 1'b0);
    frame(32'h005A3C96, 32);
    chk(got, 8'hBA);
    chk(irqPinOe, 1'b0);
    chk(controlWord, 24'h5A3C96);
    frame(32'h00000001, 32);
    digitalInputOne = 1'b1;
    step(8);
    chk(irqPinOe, 1'b0);
    frame(32'h00000000, 32);
    bitClockError = 2'h3;
    step(8);
    chk(irqPinOe, 1'b0);
    bitClockError = 2'h0;
    step(8);
    chk(irqPinOe, 1'b1);
    frame(32'h00000000, 32);
    chk(irqPinOe, 1'b0);
    wordAccept = 1'b0;
    for (int i = 1; i <= 17; i++) frame(32'(i), 24);
    chk(controlWord, 24'h000000);
    chk(ovfCnt, 1);
    wordAccept = 1'b1;
    step(60);
    chk(controlWord, 24'h000010);
    for (int m = 1; m <= 5; m++) begin
      serialModeSel = 3'(m);
      step(8);
      chk(modeUnsupported, m < 3);
      if (m == 1) frame(32'h00FFFFFE, 32);
    end
    chk(controlWord, 24'h000010);
    serialModeSel = MODE_THREE;
    rateSelect = 3'h5;
    step(12);
    chk(sampleRateKey, 24'h000005);
    calCnt = 0;
    slaveMode = 1'b1;
    for (int j = 0; j < 8; j++) begin
      {multiplierMode, frameLengthSel} = 3'(j);
      step(30);
      chk(bitClockRatio, 12'h002);
      chk(sampleRateKey, 32'h2 << (8 - j % 4 + 4 * (j / 4)));
    end
    chk(calCnt >= 8, 1'b1);
    print_verdict();
  end
endmodule
